// [ebpm_defines.svh]
// constants for the external bus port multiplexer
`ifndef EBPM_DEFINES_SVH
`define EBPM_DEFINES_SVH
`define EBPM_PORT_W 8
`define EBPM_CTL_W 3
`define EBPM_CTL_RW 0
`define EBPM_CTL_BHE 1
`define EBPM_CTL_ALE 2
`define EBPM_DIR_RESET 8'h00
`define EBPM_CTL_DIR_RESET 3'h0
`define EBPM_ADDR_CYCLES 2
`define EBPM_DATA_CYCLES 2
`endif

// [ebpm_pkg.sv]
// types for the external bus port multiplexer
`default_nettype none
package ebpm_pkg;
  typedef enum logic [1:0] {
    EBPM_MODE_SINGLE,
    EBPM_MODE_EXPAND,
    EBPM_MODE_MICRO
  } ebpm_mode_t;
  // bus request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic word;
  } ebpm_req_t;
  // general port control from the core
  typedef struct packed {
    logic [7:0] dir_wr;
    logic [7:0] low_out;
    logic [7:0] mid_out;
    logic [7:0] upper_out;
    logic [2:0] ctl_out;
  } ebpm_gpio_t;
endpackage : ebpm_pkg
`default_nettype wire

// [ebpm_pin_sync.sv]
// three-flop pin synchroniser with second/third agreement
`default_nettype none
module ebpm_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pins
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire logic [W-1:0] agree = ~(s2 ^ s3);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= (agree & s3) | (~agree & level);
    end
  end
endmodule : ebpm_pin_sync
`default_nettype wire

// [ebpm_port_mux.sv]
// external bus interface and shared port multiplexer
// Operation
// - mode pin picks mode; low is single-chip
// - bus transfers only while strobe low
// - width pin low 16-bit, high 8-bit
// - single-chip low port is direction-programmable I/O
// - reset sets all port pins input
// - expansion modes drive address 7:0 low port
// - mid port data high byte, address otherwise
// - 8-bit bus: mid port address only
// - upper port data low byte, address 23:16
// - control port gives rw, bhe, ale
`include "ebpm_defines.svh"
`default_nettype none
module ebpm_port_mux (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // board straps
  input wire logic processor_mode_select,
  input wire logic micro_mode_select,
  input wire logic bus_width_select,
  // core side
  input wire ebpm_pkg::ebpm_req_t req,
  input wire ebpm_pkg::ebpm_gpio_t gpio,
  output logic req_ready,
  output logic done,
  output logic [15:0] rdata,
  output ebpm_pkg::ebpm_mode_t mode,
  output logic [7:0] low_in,
  output logic [7:0] mid_in,
  output logic [7:0] upper_in,
  output logic [2:0] ctl_in,
  // pins
  output logic bus_strobe_n,
  input wire logic [7:0] port_low_address_i,
  output logic [7:0] port_low_address_o,
  output logic [7:0] port_low_address_oe_n,
  input wire logic [7:0] port_mid_address_data_i,
  output logic [7:0] port_mid_address_data_o,
  output logic [7:0] port_mid_address_data_oe_n,
  input wire logic [7:0] port_upper_address_data_i,
  output logic [7:0] port_upper_address_data_o,
  output logic [7:0] port_upper_address_data_oe_n,
  input wire logic [2:0] port_bus_control_i,
  output logic [2:0] port_bus_control_o,
  output logic [2:0] port_bus_control_oe_n
);
  import ebpm_pkg::*;

  // ************************************
  // pin synchronisers
  // ************************************
  logic [2:0] strap;
  logic [26:0] pins;
  ebpm_pin_sync #(.W(3)) u_strap (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin({processor_mode_select, micro_mode_select, bus_width_select}),
    .level(strap)
  );
  ebpm_pin_sync #(.W(27)) u_pins (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin({port_low_address_i, port_mid_address_data_i, port_upper_address_data_i, port_bus_control_i}),
    .level(pins)
  );

  // ************************************
  // mode and width
  // ************************************
  // mode is taken each cycle from the filtered strap; boards tie it statically
  ebpm_mode_t next_mode;
  wire logic expand = (mode != EBPM_MODE_SINGLE);
  logic wide;
  always_comb begin
    next_mode = EBPM_MODE_SINGLE;
    if (strap[2])
      next_mode = strap[1] ? EBPM_MODE_MICRO : EBPM_MODE_EXPAND;
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode <= EBPM_MODE_SINGLE;
      wide <= 1'b0;
    end else begin
      mode <= next_mode;
      wide <= ~strap[0];
    end
  end

  // ************************************
  // general port registers
  // ************************************
  logic [7:0] dir_low;
  logic [7:0] dir_mid;
  logic [7:0] dir_upper;
  logic [2:0] dir_ctl;
  logic [26:0] out_latch;
  // reset behaviour of the direction registers relies on reset held long enough
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dir_low <= `EBPM_DIR_RESET;
      dir_mid <= `EBPM_DIR_RESET;
      dir_upper <= `EBPM_DIR_RESET;
      dir_ctl <= `EBPM_CTL_DIR_RESET;
      out_latch <= '0;
    end else begin
      dir_low <= gpio.dir_wr;
      dir_mid <= gpio.dir_wr;
      dir_upper <= gpio.dir_wr;
      dir_ctl <= gpio.dir_wr[2:0];
      out_latch <= {gpio.low_out, gpio.mid_out, gpio.upper_out, gpio.ctl_out};
    end
  end
  assign low_in = pins[26:19];
  assign mid_in = pins[18:11];
  assign upper_in = pins[10:3];
  assign ctl_in = pins[2:0];

  // ************************************
  // bus cycle sequencer
  // ************************************
  typedef enum logic [1:0] {
    S_IDLE,
    S_ADDR,
    S_DATA
  } ebpm_state_t;
  ebpm_state_t state;
  ebpm_state_t next_state;
  logic [1:0] cnt;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic write;
  logic word;
  logic ale;
  wire logic take = (state == S_IDLE) && req.valid && expand;
  wire logic cnt_end = (cnt == 2'd0);
  assign req_ready = (state == S_IDLE) && expand;
  // lanes answer our own strobe on this clock; a pin filter would lag the strobe past its end
  wire logic [7:0] rd_hi = word ? port_mid_address_data_i : 8'h00;
  wire logic [7:0] rd_lo = port_upper_address_data_i;
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (take) next_state = S_ADDR;
      S_ADDR: if (cnt_end) next_state = S_DATA;
      S_DATA: if (cnt_end) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= S_IDLE;
      cnt <= 2'd0;
      addr <= '0;
      wdata <= '0;
      write <= 1'b0;
      word <= 1'b0;
      ale <= 1'b0;
      bus_strobe_n <= 1'b1;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      state <= next_state;
      done <= 1'b0;
      ale <= 1'b0;
      if (take) begin
        addr <= req.addr;
        wdata <= req.wdata;
        write <= req.write;
        word <= req.word & wide;
        cnt <= 2'(`EBPM_ADDR_CYCLES - 1);
        ale <= 1'b1;
      end else if (state == S_ADDR && cnt_end) begin
        cnt <= 2'(`EBPM_DATA_CYCLES - 1);
        bus_strobe_n <= 1'b0;
      end else if (state == S_DATA && cnt_end) begin
        bus_strobe_n <= 1'b1;
        done <= 1'b1;
        // data sampled at the end of the strobe
        rdata <= {rd_hi, rd_lo};
      end else if (cnt != 2'd0) begin
        cnt <= cnt - 2'd1;
      end
    end
  end
  // ************************************
  // pin drivers
  // ************************************
  wire logic data_phase = ~bus_strobe_n;
  wire logic mid_data = wide & data_phase;
  wire logic [7:0] mid_bus_o = mid_data ? wdata[15:8] : addr[15:8];
  wire logic [7:0] upper_bus_o = data_phase ? wdata[7:0] : addr[23:16];
  // reads release the data lanes during the strobe
  wire logic [7:0] mid_bus_oe_n = {8{mid_data & ~write}};
  wire logic [7:0] upper_bus_oe_n = {8{data_phase & ~write}};
  wire logic [2:0] ctl_bus_o = {ale, ~word, ~write};
  assign port_low_address_o = expand ? addr[7:0] : out_latch[26:19];
  assign port_low_address_oe_n = expand ? 8'h00 : ~dir_low;
  assign port_mid_address_data_o = expand ? mid_bus_o : out_latch[18:11];
  assign port_mid_address_data_oe_n = expand ? mid_bus_oe_n : ~dir_mid;
  assign port_upper_address_data_o = expand ? upper_bus_o : out_latch[10:3];
  assign port_upper_address_data_oe_n = expand ? upper_bus_oe_n : ~dir_upper;
  assign port_bus_control_o = expand ? ctl_bus_o : out_latch[2:0];
  assign port_bus_control_oe_n = expand ? 3'h0 : ~dir_ctl;

  // ************************************
  // checks
  // ************************************
  sequence s_addr_phase;
    ale && bus_strobe_n;
  endsequence
  sequence s_strobe;
    !bus_strobe_n [*2];
  endsequence
  property p_single_low;
    @(posedge sys_clk) disable iff (!reset_n) !strap[2] |=> mode == EBPM_MODE_SINGLE;
  endproperty
  a_single_low: assert property (p_single_low) else $error("mode not single");
  property p_strobe_seq;
    @(posedge sys_clk) disable iff (!reset_n) take |=> s_addr_phase ##2 s_strobe ##1 done;
  endproperty
  a_strobe_seq: assert property (p_strobe_seq) else $error("bus cycle order wrong");
  property p_width;
    @(posedge sys_clk) disable iff (!reset_n) !strap[0] |=> wide;
  endproperty
  a_width: assert property (p_width) else $error("width wrong");
  property p_gpio_dir;
    @(posedge sys_clk) disable iff (!reset_n) !expand |-> port_low_address_oe_n == ~dir_low;
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("low port direction");
  property p_reset_in;
    @(posedge sys_clk) $rose(reset_n) |-> dir_low == 8'h00 && dir_mid == 8'h00;
  endproperty
  a_reset_in: assert property (p_reset_in) else $error("port not input after reset");
  property p_low_addr;
    @(posedge sys_clk) disable iff (!reset_n) expand |-> port_low_address_o == addr[7:0];
  endproperty
  a_low_addr: assert property (p_low_addr) else $error("low address wrong");
  property p_mid_byte;
    @(posedge sys_clk) disable iff (!reset_n)
      expand && !wide |-> port_mid_address_data_o == addr[15:8] && port_mid_address_data_oe_n == 8'h00;
  endproperty
  a_mid_byte: assert property (p_mid_byte) else $error("mid port carries data");
  property p_upper_addr;
    @(posedge sys_clk) disable iff (!reset_n)
      expand && bus_strobe_n |-> port_upper_address_data_o == addr[23:16];
  endproperty
  a_upper_addr: assert property (p_upper_addr) else $error("upper address wrong");
  property p_ale_high;
    @(posedge sys_clk) disable iff (!reset_n) ale |-> bus_strobe_n ##1 !ale;
  endproperty
  a_ale_high: assert property (p_ale_high) else $error("ale outside address phase");
  // ready, strobe and lane-level checks
  property p_ready_single;
    @(posedge sys_clk) disable iff (!reset_n) !expand |-> !req_ready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("request taken in single-chip mode");
  property p_strobe_idle;
    @(posedge sys_clk) disable iff (!reset_n) state == S_IDLE |-> bus_strobe_n;
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobe low while idle");
  property p_strobe_len;
    @(posedge sys_clk) disable iff (!reset_n) $fell(bus_strobe_n) |-> s_strobe ##1 bus_strobe_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_done_once;
    @(posedge sys_clk) disable iff (!reset_n) done |=> !done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done longer than one cycle");
  property p_byte_bhe;
    @(posedge sys_clk) disable iff (!reset_n) take && !wide |=> port_bus_control_o[1];
  endproperty
  a_byte_bhe: assert property (p_byte_bhe) else $error("high byte enabled on 8-bit bus");
  property p_word_bhe;
    @(posedge sys_clk) disable iff (!reset_n) take && wide && req.word |=> !port_bus_control_o[1];
  endproperty
  a_word_bhe: assert property (p_word_bhe) else $error("high byte not enabled on word");
  property p_addr_latch;
    @(posedge sys_clk) disable iff (!reset_n)
      take |=> port_low_address_o == $past(req.addr[7:0]) && port_upper_address_data_o == $past(req.addr[23:16]);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not on ports");
  property p_mid_addr_phase;
    @(posedge sys_clk) disable iff (!reset_n)
      expand && bus_strobe_n |-> port_mid_address_data_o == addr[15:8] && port_mid_address_data_oe_n == 8'h00;
  endproperty
  a_mid_addr_phase: assert property (p_mid_addr_phase) else $error("mid address phase wrong");
  property p_mid_data;
    @(posedge sys_clk) disable iff (!reset_n)
      expand && wide && !bus_strobe_n && write |-> port_mid_address_data_o == wdata[15:8];
  endproperty
  a_mid_data: assert property (p_mid_data) else $error("mid write data wrong");
  property p_write_lanes;
    @(posedge sys_clk) disable iff (!reset_n)
      expand && !bus_strobe_n && write |-> port_upper_address_data_o == wdata[7:0] && port_upper_address_data_oe_n == 8'h00;
  endproperty
  a_write_lanes: assert property (p_write_lanes) else $error("upper write data wrong");
  property p_read_release;
    @(posedge sys_clk) disable iff (!reset_n)
      expand && !bus_strobe_n && !write |-> port_upper_address_data_oe_n == 8'hff;
  endproperty
  a_read_release: assert property (p_read_release) else $error("upper lane driven on read");
  property p_ctl_drive;
    @(posedge sys_clk) disable iff (!reset_n)
      expand |-> port_bus_control_oe_n == 3'h0 && port_bus_control_o[0] == !write;
  endproperty
  a_ctl_drive: assert property (p_ctl_drive) else $error("control port wrong");
endmodule : ebpm_port_mux
`default_nettype wire

// [ebpm_mem_model.sv]
// far-side memory model for the multiplexed expansion bus
`default_nettype none
module ebpm_mem_model (
  // clock
  input wire logic sys_clk,
  // resolved bus pins
  input wire logic strobe_n,
  input wire logic [2:0] ctl,
  input wire logic [7:0] low,
  input wire logic [7:0] mid,
  input wire logic [7:0] upper,
  input wire logic width8,
  // read drive back onto the lanes
  output logic rd_en,
  output logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // storage
  // ****************
  logic [15:0] mem [256];
  logic [7:0] a;
  logic rd = 1'b0;
  logic s_low = 1'b0;
  // drives from the latch pulse on, so slow pin filters still see settled data
  assign rd_en = rd;
  assign rd_data = width8 ? {8'h00, mem[a][7:0]} : mem[a];
  always @(posedge sys_clk) begin
    if (ctl[2]) begin
      a <= low;
      rd <= ctl[0];
    end else if (!strobe_n) begin
      s_low <= 1'b1;
      if (!ctl[0]) mem[a] <= width8 ? {mem[a][15:8], upper} : {mid, upper};
    end else if (s_low) begin
      s_low <= 1'b0;
      rd <= 1'b0;
    end
  end
endmodule : ebpm_mem_model
`default_nettype wire

// [ebpm_tb.sv]
// self-checking bench for the port multiplexer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ebpm_pkg::*;
  // ****************
  // signals
  // ****************
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic processor_mode_select = 1'b0;
  logic micro_mode_select = 1'b0;
  logic bus_width_select = 1'b0;
  ebpm_req_t req = '0;
  ebpm_gpio_t gpio = '0;
  logic req_ready, done, bus_strobe_n, rd_en;
  logic [15:0] rdata, rd_data;
  ebpm_mode_t mode;
  logic [7:0] low_in, mid_in, upper_in, pat = 8'h55;
  logic [2:0] ctl_in;
  logic [7:0] port_low_address_i, port_low_address_o, port_low_address_oe_n;
  logic [7:0] port_mid_address_data_i, port_mid_address_data_o, port_mid_address_data_oe_n;
  logic [7:0] port_upper_address_data_i, port_upper_address_data_o, port_upper_address_data_oe_n;
  logic [2:0] port_bus_control_i, port_bus_control_o, port_bus_control_oe_n;
  int error_cnt = 0;
  int n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  // undriven lines toggle so a stale value never passes
  always @(posedge sys_clk) pat <= ~pat;
  assign port_low_address_i = (port_low_address_o & ~port_low_address_oe_n) | (pat & port_low_address_oe_n);
  assign port_bus_control_i = (port_bus_control_o & ~port_bus_control_oe_n) | (pat[2:0] & port_bus_control_oe_n);
  assign port_mid_address_data_i = (port_mid_address_data_o & ~port_mid_address_data_oe_n)
    | ((rd_en ? rd_data[15:8] : pat) & port_mid_address_data_oe_n);
  assign port_upper_address_data_i = (port_upper_address_data_o & ~port_upper_address_data_oe_n)
    | ((rd_en ? rd_data[7:0] : pat) & port_upper_address_data_oe_n);
  ebpm_port_mux ebpm_port_mux_i (.sys_clk, .reset_n, .processor_mode_select, .micro_mode_select,
    .bus_width_select, .req, .gpio, .req_ready, .done, .rdata, .mode, .low_in, .mid_in, .upper_in,
    .ctl_in, .bus_strobe_n, .port_low_address_i, .port_low_address_o, .port_low_address_oe_n,
    .port_mid_address_data_i, .port_mid_address_data_o, .port_mid_address_data_oe_n,
    .port_upper_address_data_i, .port_upper_address_data_o, .port_upper_address_data_oe_n,
    .port_bus_control_i, .port_bus_control_o, .port_bus_control_oe_n);
  ebpm_mem_model ebpm_mem_model_i (.sys_clk(sys_clk), .strobe_n(bus_strobe_n), .ctl(port_bus_control_i),
    .low(port_low_address_i), .mid(port_mid_address_data_i), .upper(port_upper_address_data_i),
    .width8(bus_width_select), .rd_en(rd_en), .rd_data(rd_data));
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // reset held two edges; the synchronous reset clears every filter stage at once
  task automatic restart(input logic p, input logic m, input logic w);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    processor_mode_select <= p;
    micro_mode_select <= m;
    bus_width_select <= w;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : restart
  task automatic test_reset;
    gpio <= '{8'hff, 8'hff, 8'hff, 8'hff, 3'h7};
    restart(1'b0, 1'b0, 1'b0);
    reset_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check({port_low_address_oe_n, port_mid_address_data_oe_n, port_upper_address_data_oe_n}, 24'hffffff);
    check(port_bus_control_oe_n, 3'h7);
    @(posedge sys_clk);
    gpio <= '0;
    restart(1'b0, 1'b0, 1'b0);
    check(mode, EBPM_MODE_SINGLE);
    check(req_ready, 1'b0);
    req <= '{1'b1, 1'b1, 24'h000001, 16'h1234, 1'b1};
    repeat (8) begin
      @(negedge sys_clk);
      check({bus_strobe_n, done}, 2'h2);
    end
    @(posedge sys_clk);
    req <= '0;
  endtask : test_reset
  task automatic test_gpio;
    gpio <= '{8'ha5, 8'h3c, 8'hc3, 8'h5a, 3'h5};
    repeat (6) @(negedge sys_clk);
    check({port_low_address_oe_n, port_mid_address_data_oe_n, port_upper_address_data_oe_n}, 24'h5a5a5a);
    check({port_low_address_o, port_mid_address_data_o, port_upper_address_data_o} & 24'ha5a5a5,
      24'h3cc35a & 24'ha5a5a5);
    check(low_in & 8'ha5, 8'h3c & 8'ha5);
    check({port_bus_control_oe_n, port_bus_control_o & 3'h5}, 6'h15);
    check(mid_in & 8'ha5, 8'hc3 & 8'ha5);
    check(upper_in & 8'ha5, 8'h5a & 8'ha5);
    check(ctl_in & 3'h5, 3'h5);
  endtask : test_gpio
  task automatic bus_op(input logic w, input logic [23:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    int lo;
    @(posedge sys_clk);
    req <= '{1'b1, w, a, d, 1'b1};
    @(negedge sys_clk);
    check(req_ready, 1'b1);
    @(posedge sys_clk);
    req <= '0;
    n = 0;
    lo = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (port_bus_control_o[2] !== 1'b1 && n < 4);
    check({bus_strobe_n, port_bus_control_oe_n, port_bus_control_o}, {4'h8, 1'b1, bus_width_select, !w});
    check({port_upper_address_data_o, port_mid_address_data_o, port_low_address_o}, a);
    check({port_low_address_oe_n, port_mid_address_data_oe_n, port_upper_address_data_oe_n}, 24'h0);
    repeat (4) begin
      @(negedge sys_clk);
      if (bus_strobe_n === 1'b0) begin
        lo++;
        check(port_bus_control_o[2], 1'b0);
        if (bus_width_select) check({port_mid_address_data_oe_n, port_mid_address_data_o}, a[15:8]);
        else if (w) check(port_mid_address_data_o, d[15:8]);
        else check(port_mid_address_data_oe_n, 8'hff);
        if (w) check(port_upper_address_data_o, d[7:0]);
        else check(port_upper_address_data_oe_n, 8'hff);
      end
    end
    check({done, 8'(lo)}, 9'h102);
    q = rdata;
  endtask : bus_op
  task automatic test_bus(input logic m, input logic w8);
    logic [15:0] q;
    restart(1'b1, m, w8);
    check(mode, m ? EBPM_MODE_MICRO : EBPM_MODE_EXPAND);
    bus_op(1'b1, {16'hc35a, 6'h09, m, w8}, 16'hbeef, q);
    bus_op(1'b0, {16'hc35a, 6'h09, m, w8}, 16'h0000, q);
    check(q, w8 ? 16'h00ef : 16'hbeef);
  endtask : test_bus
  // ****************
  // sequence
  // ****************
  initial begin
    test_reset();
    test_gpio();
    for (int i = 0; i < 4; i++) test_bus(i[1], i[0]);
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
